/* File: src/psa_arbiter.sv */
// Power state request arbiter: switch-off, sleep and wake arbitration and resource modes.
// Assumes an external sequencer answers each seq_start_out with one seq_done_in pulse.
// How it works
// - Switch-off requests win over sleep and switch-on, with no gating.
// - In OFF, an ungated switch-on request acts once no external switch-off request remains.
// - One shared switch-off delay of 0, 1, 2 or 4 seconds.
// - Reset depth selects hardware-level or software-level register reset.
// - Shutdown runs the matching off sequence and stays in OFF.
// - Cold restart runs off, then off-to-active unless switch-on is gated.
// - Watchdog source disabled after reset; software enables, then may lock it.
// - Keep-on bit and hold pin each keep the device on alone.
// - Sleep starts only with no unmasked interrupt pending.
// - Wake comes from interrupt or released sleep pin, only in SLEEP.
// - Accepted wake runs sleep-to-active; an off request in SLEEP runs sleep-to-off.
// - Sleep pin active low by default; assertion requests sleep.
// - Direct enable pin active high by default; assertion wakes its resources.
// - Software may invert both pin polarities.
// - Direct enable resources switch together at once, bypassing the sequencer.
// - Sleep-only resources follow the sequencer's stored order.
// - Unassigned resources never sleep.
module psa_arbiter #(
  parameter int SEC_CYCLES = psa_pkg::SEC_CYCLES
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     nrst_in,
  input  wire logic [3:0]               addr_in,
  input  wire logic [7:0]               wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  output logic      [7:0]               rdata_out,
  input  wire logic                     sleep_request_pin_in,
  input  wire logic                     direct_enable_pin_in,
  input  wire logic                     forced_off_pin_in,
  input  wire logic                     hold_on_pin_in,
  input  wire logic                     power_button_pin_in,
  input  wire logic                     thermal_shutdown_in,
  input  wire logic                     system_undervoltage_event_in,
  input  wire logic                     converter_shutdown_event_in,
  input  wire logic                     watchdog_expired_in,
  input  wire logic                     on_request_in,
  input  wire logic                     on_gate_in,
  input  wire logic                     irq_pending_in,
  input  wire logic                     seq_done_in,
  output logic                          seq_start_out,
  output logic      [4:0]               seq_sel_out,
  output logic                          hardware_reset_level_out,
  output logic                          software_reset_level_out,
  output logic      [psa_pkg::NRES-1:0] res_active_out
);
  typedef struct packed {
    psa_pkg::psa_state_type   state;
    logic                     seq_start;
    logic [4:0]               seq_sel;
    logic [7:0]               ctrl;
    logic [7:0]               pol;
    logic                     wd_en;
    logic                     wd_lock;
    logic [psa_pkg::NRES-1:0] slp_asg;
    logic [psa_pkg::NRES-1:0] en_asg;
    logic                     seq_sleep;
    logic                     off_hw;
    logic                     off_cr;
    logic                     rst_hw;
    logic                     rst_sw;
    logic                     tmr_start;
    logic [7:0]               rdata;
    logic [psa_pkg::NRES-1:0] res_act;
  } psa_arb_type;

  psa_arb_type r;
  psa_arb_type next_r;
  logic [psa_pkg::NPIN-1:0] pins;
  logic                     tmr_done;
  logic                     slp_act;
  logic                     en_act;
  logic                     keep_off;
  logic                     imm_off;
  logic                     dly_off;
  logic                     ext_off;
  logic                     sleep_go;
  logic                     wake;
  logic                     powered;

  psa_pin_sync #(
    .W (psa_pkg::NPIN)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .pin_in      ({power_button_pin_in, hold_on_pin_in, forced_off_pin_in,
                   direct_enable_pin_in, sleep_request_pin_in}),
    .level_out   (pins)
  );

  psa_off_timer #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .start_in    (r.tmr_start),
    .sel_in      (r.ctrl[psa_pkg::CTRL_DLY_HI:psa_pkg::CTRL_DLY_LO]),
    .done_out    (tmr_done)
  );

  // Pin activity after the software polarity choice.
  assign slp_act = pins[psa_pkg::PIN_SLEEP] ^ ~r.pol[psa_pkg::POL_SLEEP];
  assign en_act  = pins[psa_pkg::PIN_EN] ^ r.pol[psa_pkg::POL_EN];

  // Keep-on loss counts as an off request only when neither keep-on condition holds.
  assign keep_off = !r.ctrl[psa_pkg::CTRL_KEEP_ON] && !pins[psa_pkg::PIN_HOLD];
  assign imm_off  = thermal_shutdown_in || r.ctrl[psa_pkg::CTRL_SOFTWARE_RESET_BIT]
                    || system_undervoltage_event_in || keep_off;
  assign dly_off  = !pins[psa_pkg::PIN_BTN] || pins[psa_pkg::PIN_FOFF]
                    || converter_shutdown_event_in
                    || (r.wd_en && watchdog_expired_in);
  assign ext_off  = thermal_shutdown_in || system_undervoltage_event_in || dly_off;
  assign sleep_go = slp_act && r.ctrl[psa_pkg::CTRL_SLP_EN] && !irq_pending_in;
  assign wake     = irq_pending_in || !(slp_act && r.ctrl[psa_pkg::CTRL_SLP_EN]);
  assign powered  = (r.state != psa_pkg::ST_OFF) && (r.state != psa_pkg::ST_UP);

  always_comb
  begin
    next_r           = r;
    next_r.seq_start = 1'b0;
    next_r.rst_hw    = 1'b0;
    next_r.rst_sw    = 1'b0;
    next_r.tmr_start = 1'b0;

    if (rd_in)
    begin
      case (addr_in)
        psa_pkg::REG_CTRL:    next_r.rdata = r.ctrl;
        psa_pkg::REG_POL:     next_r.rdata = r.pol;
        psa_pkg::REG_WDOG:    next_r.rdata = {6'h00, r.wd_lock, r.wd_en};
        psa_pkg::REG_SLP_ASG: next_r.rdata = r.slp_asg;
        psa_pkg::REG_EN_ASG:  next_r.rdata = r.en_asg;
        psa_pkg::REG_STATE:   next_r.rdata = r.state;
        psa_pkg::REG_RES:     next_r.rdata = r.res_act;
        psa_pkg::REG_PINS:    next_r.rdata = {5'h00, r.seq_sleep, en_act, slp_act};
        default:              next_r.rdata = 8'h00;
      endcase
    end

    if (wr_in)
    begin
      case (addr_in)
        psa_pkg::REG_CTRL:    next_r.ctrl = wdata_in & 8'h7f;
        psa_pkg::REG_POL:     next_r.pol = wdata_in & 8'h03;
        psa_pkg::REG_SLP_ASG: next_r.slp_asg = wdata_in;
        psa_pkg::REG_EN_ASG:  next_r.en_asg = wdata_in;
        psa_pkg::REG_WDOG:
        begin
          // Once locked, the watchdog control ignores writes until reset.
          if (!r.wd_lock)
          begin
            next_r.wd_en   = wdata_in[psa_pkg::WD_EN];
            next_r.wd_lock = wdata_in[psa_pkg::WD_LOCK];
          end
        end
        default:
        begin
        end
      endcase
    end

    case (r.state)
      psa_pkg::ST_OFF:
      begin
        if (!ext_off && on_request_in && !on_gate_in)
        begin
          next_r.state     = psa_pkg::ST_UP;
          next_r.seq_start = 1'b1;
          next_r.seq_sel   = psa_pkg::SEQ_OFF_TO_ACTIVE_SEQUENCE;
        end
      end
      psa_pkg::ST_ACTIVE, psa_pkg::ST_SLEEP:
      begin
        if (imm_off || dly_off)
        begin
          // Button and hold/keep-on losses have fixed depth and action.
          if (imm_off)
          begin
            next_r.off_hw = (thermal_shutdown_in || r.ctrl[psa_pkg::CTRL_SOFTWARE_RESET_BIT]
                            || system_undervoltage_event_in) && r.ctrl[psa_pkg::CTRL_LVL_HW];
            next_r.off_cr = (thermal_shutdown_in || r.ctrl[psa_pkg::CTRL_SOFTWARE_RESET_BIT]
                            || system_undervoltage_event_in) && r.ctrl[psa_pkg::CTRL_ACT_CR];
            next_r.state     = psa_pkg::ST_DOWN;
            next_r.seq_start = 1'b1;
            next_r.seq_sel   = (r.state == psa_pkg::ST_SLEEP) ? psa_pkg::SEQ_SLEEP_TO_OFF_SEQUENCE
                                                              : psa_pkg::SEQ_ACTIVE_TO_OFF_SEQUENCE;
          end
          else
          begin
            next_r.off_hw    = !pins[psa_pkg::PIN_BTN] || r.ctrl[psa_pkg::CTRL_LVL_HW];
            next_r.off_cr    = pins[psa_pkg::PIN_BTN] && r.ctrl[psa_pkg::CTRL_ACT_CR];
            next_r.state     = psa_pkg::ST_WAIT;
            next_r.tmr_start = 1'b1;
          end
          next_r.ctrl[psa_pkg::CTRL_SOFTWARE_RESET_BIT] = 1'b0;
        end
        else if (r.state == psa_pkg::ST_ACTIVE && sleep_go)
        begin
          next_r.state     = psa_pkg::ST_TOSLP;
          next_r.seq_start = 1'b1;
          next_r.seq_sel   = psa_pkg::SEQ_ACTIVE_TO_SLEEP_SEQUENCE;
        end
        else if (r.state == psa_pkg::ST_SLEEP && wake)
        begin
          next_r.state     = psa_pkg::ST_WAKE;
          next_r.seq_start = 1'b1;
          next_r.seq_sel   = psa_pkg::SEQ_SLEEP_TO_ACTIVE_SEQUENCE;
          next_r.seq_sleep = 1'b0;
        end
      end
      psa_pkg::ST_WAIT:
      begin
        // A zero-delay request cuts the pending delay short.
        if (imm_off || tmr_done)
        begin
          next_r.state     = psa_pkg::ST_DOWN;
          next_r.seq_start = 1'b1;
          next_r.seq_sel   = r.seq_sleep ? psa_pkg::SEQ_SLEEP_TO_OFF_SEQUENCE : psa_pkg::SEQ_ACTIVE_TO_OFF_SEQUENCE;
          next_r.ctrl[psa_pkg::CTRL_SOFTWARE_RESET_BIT] = 1'b0;
        end
      end
      psa_pkg::ST_DOWN:
      begin
        if (seq_done_in)
        begin
          next_r.seq_sleep = 1'b0;
          next_r.rst_hw    = r.off_hw;
          next_r.rst_sw    = !r.off_hw;
          next_r.ctrl      = psa_pkg::CTRL_RST;
          if (r.off_hw)
          begin
            next_r.pol     = psa_pkg::POL_RST;
            next_r.slp_asg = psa_pkg::ASG_RST;
            next_r.en_asg  = psa_pkg::ASG_RST;
          end
          if (r.off_cr && !on_gate_in)
          begin
            next_r.state     = psa_pkg::ST_UP;
            next_r.seq_start = 1'b1;
            next_r.seq_sel   = psa_pkg::SEQ_OFF_TO_ACTIVE_SEQUENCE;
          end
          else
            next_r.state = psa_pkg::ST_OFF;
        end
      end
      psa_pkg::ST_UP:
      begin
        if (seq_done_in)
        begin
          next_r.state                       = psa_pkg::ST_ACTIVE;
          next_r.ctrl[psa_pkg::CTRL_KEEP_ON] = 1'b1;
        end
      end
      psa_pkg::ST_TOSLP:
      begin
        if (seq_done_in)
        begin
          next_r.state     = psa_pkg::ST_SLEEP;
          next_r.seq_sleep = 1'b1;
        end
      end
      psa_pkg::ST_WAKE:
      begin
        if (seq_done_in)
          next_r.state = psa_pkg::ST_ACTIVE;
      end
      default:
        next_r.state = psa_pkg::ST_OFF;
    endcase

    for (int i = 0; i < psa_pkg::NRES; i++)
    begin
      case ({r.en_asg[i], r.slp_asg[i]})
        2'b00:   next_r.res_act[i] = powered;
        2'b01:   next_r.res_act[i] = powered && !r.seq_sleep;
        2'b10:   next_r.res_act[i] = powered && en_act;
        default: next_r.res_act[i] = powered && (en_act || !r.seq_sleep);
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      r         <= '0;
      r.state   <= psa_pkg::ST_OFF;
      r.ctrl    <= psa_pkg::CTRL_RST;
      r.pol     <= psa_pkg::POL_RST;
      r.slp_asg <= psa_pkg::ASG_RST;
      r.en_asg  <= psa_pkg::ASG_RST;
    end
    else
      r <= next_r;
  end

  assign rdata_out                = r.rdata;
  assign seq_start_out            = r.seq_start;
  assign seq_sel_out              = r.seq_sel;
  assign hardware_reset_level_out = r.rst_hw;
  assign software_reset_level_out = r.rst_sw;
  assign res_active_out           = r.res_act;

  sequence s_down_done;
    r.state == psa_pkg::ST_DOWN && seq_done_in;
  endsequence

  sequence s_restart;
    r.state == psa_pkg::ST_UP && r.seq_start && r.seq_sel == psa_pkg::SEQ_OFF_TO_ACTIVE_SEQUENCE;
  endsequence

  property p_off_prio;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (r.state == psa_pkg::ST_ACTIVE && imm_off) |=> (r.state == psa_pkg::ST_DOWN && r.seq_start);
  endproperty
  a_off_prio: assert property (p_off_prio) else $error("Off request not taken.");

  property p_restart;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (s_down_done and (r.off_cr && !on_gate_in)) |=> s_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("Cold restart missing.");

  property p_shutdown;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (s_down_done and !r.off_cr) |=> r.state == psa_pkg::ST_OFF;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("Shutdown left OFF.");

  property p_depth;
    @(posedge core_clk_in) disable iff (!nrst_in)
    s_down_done |=> (hardware_reset_level_out == $past(r.off_hw))
                    && (software_reset_level_out != $past(r.off_hw));
  endproperty
  a_depth: assert property (p_depth) else $error("Wrong reset depth.");

  property p_wd_lock;
    @(posedge core_clk_in) disable iff (!nrst_in)
    r.wd_lock |=> r.wd_lock && $stable(r.wd_en);
  endproperty
  a_wd_lock: assert property (p_wd_lock) else $error("Watchdog lock broken.");

  property p_keep;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (r.state == psa_pkg::ST_ACTIVE && pins[psa_pkg::PIN_HOLD] && !thermal_shutdown_in
     && !system_undervoltage_event_in && !r.ctrl[psa_pkg::CTRL_SOFTWARE_RESET_BIT])
    |=> r.state != psa_pkg::ST_DOWN;
  endproperty
  a_keep: assert property (p_keep) else $error("Hold pin ignored.");

  property p_irq_blocks;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (r.state == psa_pkg::ST_ACTIVE && irq_pending_in) |=> r.state != psa_pkg::ST_TOSLP;
  endproperty
  a_irq_blocks: assert property (p_irq_blocks) else $error("Sleep with interrupt.");

  property p_wake_src;
    @(posedge core_clk_in) disable iff (!nrst_in)
    $rose(r.state == psa_pkg::ST_WAKE) |-> $past(r.state) == psa_pkg::ST_SLEEP;
  endproperty
  a_wake_src: assert property (p_wake_src) else $error("Wake outside SLEEP.");

  property p_unassigned;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (powered && !r.en_asg[0] && !r.slp_asg[0]) |=> res_active_out[0];
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("Unassigned resource slept.");
endmodule : psa_arbiter

/* File: src/psa_pkg.sv */
// Constants, register map and state codes for the power state request arbiter.
// Assumes a single 20 MHz core clock and an external sequencer that runs the stored sequences.
package psa_pkg;
  localparam int CLK_FREQ_HZ  = 20_000_000;
  localparam int DELAY_UNIT_S = 1;
  localparam int SEC_CYCLES   = CLK_FREQ_HZ * DELAY_UNIT_S;
  localparam int DLY_W        = 27;
  localparam int NRES         = 8;
  localparam int NPIN         = 5;

  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_POL     = 4'h1;
  localparam logic [3:0] REG_WDOG    = 4'h2;
  localparam logic [3:0] REG_SLP_ASG = 4'h3;
  localparam logic [3:0] REG_EN_ASG  = 4'h4;
  localparam logic [3:0] REG_STATE   = 4'h5;
  localparam logic [3:0] REG_RES     = 4'h6;
  localparam logic [3:0] REG_PINS    = 4'h7;

  localparam int CTRL_KEEP_ON = 0;
  localparam int CTRL_SOFTWARE_RESET_BIT  = 1;
  localparam int CTRL_DLY_LO  = 2;
  localparam int CTRL_DLY_HI  = 3;
  localparam int CTRL_LVL_HW  = 4;
  localparam int CTRL_ACT_CR  = 5;
  localparam int CTRL_SLP_EN  = 6;
  localparam int POL_SLEEP    = 0;
  localparam int POL_EN       = 1;
  localparam int WD_EN        = 0;
  localparam int WD_LOCK      = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] POL_RST  = 8'h00;
  localparam logic [7:0] ASG_RST  = 8'h00;

  localparam int PIN_SLEEP = 0;
  localparam int PIN_EN    = 1;
  localparam int PIN_FOFF  = 2;
  localparam int PIN_HOLD  = 3;
  localparam int PIN_BTN   = 4;

  localparam logic [4:0] SEQ_NONE    = 5'h00;
  localparam logic [4:0] SEQ_OFF_TO_ACTIVE_SEQUENCE = 5'h01;
  localparam logic [4:0] SEQ_ACTIVE_TO_OFF_SEQUENCE = 5'h02;
  localparam logic [4:0] SEQ_ACTIVE_TO_SLEEP_SEQUENCE = 5'h04;
  localparam logic [4:0] SEQ_SLEEP_TO_ACTIVE_SEQUENCE = 5'h08;
  localparam logic [4:0] SEQ_SLEEP_TO_OFF_SEQUENCE = 5'h10;

  typedef enum logic [7:0] {
    ST_OFF    = 8'h01,
    ST_ACTIVE = 8'h02,
    ST_SLEEP  = 8'h04,
    ST_WAIT   = 8'h08,
    ST_DOWN   = 8'h10,
    ST_UP     = 8'h20,
    ST_TOSLP  = 8'h40,
    ST_WAKE   = 8'h80
  } psa_state_type;

  function automatic logic [2:0] delay_seconds(input logic [1:0] sel);
    case (sel)
      2'h0:    delay_seconds = 3'h0;
      2'h1:    delay_seconds = 3'h1;
      2'h2:    delay_seconds = 3'h2;
      default: delay_seconds = 3'h4;
    endcase
  endfunction : delay_seconds
endpackage : psa_pkg

/* File: src/psa_pin_sync.sv */
// Three-stage synchroniser for asynchronous pins with agreement filter.
// Assumes pins are slow levels; a change is taken once stages two and three agree.
module psa_pin_sync #(
  parameter int W = 5
) (
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } psa_sync_type;

  psa_sync_type r;
  psa_sync_type next_r;

  always_comb
  begin
    next_r     = r;
    next_r.ff1 = pin_in;
    next_r.ff2 = r.ff1;
    next_r.ff3 = r.ff2;
    for (int i = 0; i < W; i++)
    begin
      if (r.ff2[i] == r.ff3[i])
        next_r.q[i] = r.ff3[i];
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign level_out = r.q;
endmodule : psa_pin_sync

/* File: src/psa_off_timer.sv */
// Shared switch-off delay timer: 0, 1, 2 or 4 seconds, one done pulse per start.
// Assumes start is a one-cycle pulse; a new start restarts the count.
module psa_off_timer #(
  parameter int SEC_CYCLES = psa_pkg::SEC_CYCLES
) (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       start_in,
  input  wire logic [1:0] sel_in,
  output logic            done_out
);
  typedef struct packed {
    logic [psa_pkg::DLY_W-1:0] cnt;
    logic                      busy;
    logic                      done;
  } psa_tmr_type;

  psa_tmr_type r;
  psa_tmr_type next_r;
  logic [psa_pkg::DLY_W-1:0] target;

  assign target = psa_pkg::DLY_W'(SEC_CYCLES * int'(psa_pkg::delay_seconds(sel_in)));

  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    if (start_in)
    begin
      next_r.busy = (target != '0);
      next_r.done = (target == '0);
      next_r.cnt  = target - 1'b1;
    end
    else if (r.busy)
    begin
      if (r.cnt == '0)
      begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
      else
        next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign done_out = r.done;

  property p_zero_delay;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (start_in && sel_in == 2'h0) |=> done_out;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("Zero delay not immediate.");
endmodule : psa_off_timer

/* File: testbench/psa_seq_model.sv */
// Behavioural sequencer partner: answers each sequence start with one done pulse.
// Assumes the arbiter keeps one sequence outstanding; latency is set by the bench.
module psa_seq_model (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       seq_start_in,
  input  wire logic [3:0] lat_in,
  output logic            seq_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic       busy;
  // The stored resource order is modelled as a plain wait, so slow and prompt answers both occur.
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt          <= 4'h0;
      busy         <= 1'b0;
      seq_done_out <= 1'b0;
    end
    else
    begin
      seq_done_out <= 1'b0;
      if (seq_start_in)
      begin
        busy <= 1'b1;
        cnt  <= lat_in;
      end
      else if (busy && cnt == 4'h0)
      begin
        busy         <= 1'b0;
        seq_done_out <= 1'b1;
      end
      else if (busy)
        cnt <= cnt - 4'h1;
    end
  end
endmodule : psa_seq_model

/* File: testbench/power_state_request_arbiter_bench.sv */
// Self-checking bench for the power state request arbiter with a sequencer partner.
// Assumes SEC_CYCLES of 10, so one second of switch-off delay lasts ten clocks.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module power_state_request_arbiter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, nrst = 0, wr = 0, rd = 0, slp = 1, en = 1, foff = 0, hold = 0;
  logic       on_req = 0, gate = 0, irq = 0, done, start, hw, sw, therm = 0;
  logic [3:0] addr = 4'h0, lat = 4'h3;
  logic [7:0] wdata = 8'h00, rdata, res, rv;
  logic [4:0] sel, last_sel = 5'h00;
  int         cyc = 0, err_total = 0, n_compared = 0, n_hw = 0, n_sw = 0;
  always #25 clk = ~clk;
  psa_arbiter #(.SEC_CYCLES(10)) i_dut (
    .core_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sleep_request_pin_in(slp),
    .direct_enable_pin_in(en), .forced_off_pin_in(foff), .hold_on_pin_in(hold),
    .power_button_pin_in(1'b1), .thermal_shutdown_in(therm),
    .system_undervoltage_event_in(1'b0), .converter_shutdown_event_in(1'b0),
    .watchdog_expired_in(1'b0), .on_request_in(on_req), .on_gate_in(gate),
    .irq_pending_in(irq), .seq_done_in(done), .seq_start_out(start), .seq_sel_out(sel),
    .hardware_reset_level_out(hw), .software_reset_level_out(sw), .res_active_out(res));
  psa_seq_model i_seq (.core_clk_in(clk), .nrst_in(nrst), .seq_start_in(start),
    .lat_in(lat), .seq_done_out(done));
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (start)
      last_sel <= sel;
    if (sw)
      n_sw <= n_sw + 1;
    if (hw)
      n_hw <= n_hw + 1;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand from the cycle after the strobe until the next read, so the edge closing that cycle takes them.
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    rv = rdata;
  endtask : rd_reg
  task automatic wait_state(input logic [7:0] s);
    rv = 8'hxx;
    for (int i = 0; i < 60 && rv !== s; i++)
      rd_reg(4'h5);
  endtask : wait_state
  task automatic t_reset;
    rd_reg(4'h2);
    `CHK(rv, 8'h00)
    rd_reg(4'h5);
    `CHK(rv, 8'h01)
    rd_reg(4'h8);
    `CHK(rv, 8'h00)
    $display("test reset ended");
  endtask : t_reset
  task automatic t_on_wdog;
    on_req <= 1'b1;
    wait_state(8'h02);
    `CHK(rv, 8'h02)
    `CHK(last_sel, psa_pkg::SEQ_OFF_TO_ACTIVE_SEQUENCE)
    on_req <= 1'b0;
    rd_reg(4'h6);
    `CHK(rv, 8'hff)
    wr_reg(4'h2, 8'h03);
    wr_reg(4'h2, 8'h00);
    rd_reg(4'h2);
    `CHK(rv, 8'h03)
    $display("test power-on and watchdog ended");
  endtask : t_on_wdog
  task automatic t_sleep;
    wr_reg(4'h3, 8'h0f);
    wr_reg(4'h4, 8'h3c);
    wr_reg(4'h0, 8'h41);
    irq <= 1'b1;
    slp <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(4'h5);
    `CHK(rv, 8'h02)
    irq <= 1'b0;
    wait_state(8'h04);
    `CHK(rv, 8'h04)
    `CHK(last_sel, psa_pkg::SEQ_ACTIVE_TO_SLEEP_SEQUENCE)
    rd_reg(4'h6);
    `CHK(rv, 8'hfc)
    en <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(4'h6);
    `CHK(rv, 8'hc0)
    en <= 1'b1;
    repeat (8) @(posedge clk);
    rd_reg(4'h6);
    `CHK(rv, 8'hfc)
    slp <= 1'b1;
    wait_state(8'h02);
    `CHK(rv, 8'h02)
    `CHK(last_sel, psa_pkg::SEQ_SLEEP_TO_ACTIVE_SEQUENCE)
    wr_reg(4'h1, 8'h01);
    wait_state(8'h04);
    `CHK(rv, 8'h04)
    wr_reg(4'h1, 8'h00);
    wait_state(8'h02);
    `CHK(rv, 8'h02)
    $display("test sleep and wake ended");
  endtask : t_sleep
  task automatic t_off;
    int t0, s0;
    wr_reg(4'h0, 8'h45);
    lat     <= 4'h0;
    s0      = n_sw;
    on_req  <= 1'b1;
    foff    <= 1'b1;
    t0 = cyc;
    repeat (100) if (start !== 1'b1) @(negedge clk);
    `CHK((cyc - t0 >= 10 && cyc - t0 <= 30), 1'b1)
    `CHK(sel, psa_pkg::SEQ_ACTIVE_TO_OFF_SEQUENCE)
    repeat (30) @(negedge clk);
    rd_reg(4'h5);
    `CHK(rv, 8'h01)
    `CHK(n_sw, s0 + 1)
    foff <= 1'b0;
    wait_state(8'h02);
    `CHK(rv, 8'h02)
    on_req <= 1'b0;
    $display("test delayed off ended");
  endtask : t_off
  task automatic t_hold;
    int s0;
    hold <= 1'b1;
    repeat (8) @(posedge clk);
    wr_reg(4'h0, 8'h00);
    repeat (20) @(posedge clk);
    rd_reg(4'h5);
    `CHK(rv, 8'h02)
    s0   = n_sw;
    hold <= 1'b0;
    wait_state(8'h01);
    `CHK(rv, 8'h01)
    `CHK(last_sel, psa_pkg::SEQ_ACTIVE_TO_OFF_SEQUENCE)
    `CHK(n_sw, s0 + 1)
    $display("test hold release ended");
  endtask : t_hold
  // A one-cycle thermal pulse with hardware depth and cold restart, then the same with gating.
  task automatic t_restart;
    int h0;
    on_req <= 1'b1;
    wait_state(8'h02);
    on_req <= 1'b0;
    wr_reg(4'h0, 8'h31);
    h0    = n_hw;
    therm <= 1'b1;
    @(posedge clk);
    therm <= 1'b0;
    wait_state(8'h02);
    `CHK(rv, 8'h02)
    `CHK(last_sel, psa_pkg::SEQ_OFF_TO_ACTIVE_SEQUENCE)
    `CHK(n_hw, h0 + 1)
    rd_reg(4'h3);
    `CHK(rv, 8'h00)
    wr_reg(4'h0, 8'h31);
    gate  <= 1'b1;
    therm <= 1'b1;
    @(posedge clk);
    therm <= 1'b0;
    wait_state(8'h01);
    `CHK(rv, 8'h01)
    gate <= 1'b0;
    $display("test thermal restart ended");
  endtask : t_restart
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    fork
      begin
        t_reset();
        t_on_wdog();
        t_sleep();
        t_off();
        t_hold();
        t_restart();
      end
      begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("[FAIL] %0t timeout", $time);
      end
    join_any
    tally_and_finish();
  end
endmodule : power_state_request_arbiter_bench
